//--- dv/gpio_port_monitor.sv
// Purpose: port checks for the gpio block
// Assumes: one clock domain, registered outputs
// Notes:   live_q hides the first edge after reset
`timescale 1ns/1ps
`default_nettype none
module gpio_port_monitor
  import gpio_pkg::*;
(
  input wire logic       clk_i, nrst_i, sfr_wr_i, sfr_rd_i, debug_mode_i, port0_irq_o,
  input wire logic       dbg_data_line_oe_i, low_supply_drive_boost_o,
  input wire logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, pad_out_o, pad_oe_o,
  input wire logic [7:0] pull_up_o, pull_down_o,
  input wire logic [5:0] observation_output_select_i, radio_observe_signal_i
);
  logic live_q; // low until one edge after reset, so a one-cycle $past never sees reset
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i) live_q <= 1'b0;
    else live_q <= 1'b1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_dbg;
    live_q && debug_mode_i && $past(debug_mode_i);
  endsequence
  sequence s_mask_off;
    sfr_wr_i && sfr_addr_i == ADDR_PORT0_MASK && sfr_wdata_i[3:0] == 4'h0;
  endsequence
  property p_dbg_pull; s_dbg |-> (pull_up_o[7:6] | pull_down_o[7:6]) == 2'b00; endproperty
  a_dbg_pull: assert property (p_dbg_pull) else $error("pull on debug pin");
  property p_dbg_clk; s_dbg |-> !pad_oe_o[6]; endproperty
  a_dbg_clk: assert property (p_dbg_clk) else $error("debug clock pin driven");
  property p_dbg_data; s_dbg |-> pad_oe_o[7] == $past(dbg_data_line_oe_i); endproperty
  a_dbg_data: assert property (p_dbg_data) else $error("debug data enable lost");
  property p_obs;
    live_q && $past(observation_output_select_i[2])
      |-> pad_oe_o[0] && pad_out_o[0] == $past(radio_observe_signal_i[2]);
  endproperty
  a_obs: assert property (p_obs) else $error("observation not on pin");
  property p_irq_off; s_mask_off |-> ##2 !port0_irq_o; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with mask clear");
  property p_port_nib;
    sfr_rd_i && (sfr_addr_i == ADDR_PORT0_DATA || sfr_addr_i == ADDR_PORT1_DATA)
      |=> sfr_rdata_o[7:4] == 4'h0;
  endproperty
  a_port_nib: assert property (p_port_nib) else $error("port upper nibble set");
  property p_boost;
    live_q && $changed(low_supply_drive_boost_o) |-> $past(sfr_wr_i, 2)
      && $past(sfr_addr_i, 2) == ADDR_PULL_DRIVE
      && low_supply_drive_boost_o == $past(sfr_wdata_i[5], 2);
  endproperty
  a_boost: assert property (p_boost) else $error("boost moved alone");
  property p_hd_pull; (pull_up_o[5:4] | pull_down_o[5:4]) == 2'b00; endproperty
  a_hd_pull: assert property (p_hd_pull) else $error("pull on high-drive pin");
endmodule
bind small_gpio_port_block gpio_port_monitor i_gpio_port_monitor (.*);
`default_nettype wire

//--- dv/pin_world.sv
// Purpose: pads and the outside parts wired to them
// Assumes: drv_i is what outside parts push where drv_en_i is set
// Notes:   a pin nobody holds flips each cycle, never a fixed guess
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  input  wire logic       clk_i,
  input  wire logic [7:0] out_i, oe_i, pu_i, pd_i, drv_i, drv_en_i,
  output logic      [7:0] lvl_o
);
  logic tog_q = 1'b0; // stands in for an unknown floating level
  always_ff @(posedge clk_i) tog_q <= !tog_q;
  // our pad wins, then the outside, then a pull
  always_comb
    for (int n = 0; n < 8; n++)
      lvl_o[n] = oe_i[n] ? out_i[n] : drv_en_i[n] ? drv_i[n] : pu_i[n] | (!pd_i[n] & tog_q);
endmodule
`default_nettype wire

//--- dv/tb.sv
// Purpose: directed bench for the small gpio port block
// Assumes: pin_world sets pin levels; inputs move on falling edges
// Notes:   a reset in mid-run returns every register to default
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gpio_pkg::*;
  logic        clk_i = 0, nrst_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, sfr_bit_wr_i = 0;
  logic        sfr_bit_val_i = 0, external_data_space_rd_i = 0, dplus_i = 0, debug_mode_i = 0;
  logic        dbg_data_line_out_i = 0, dbg_data_line_oe_i = 0, low_supply_drive_boost_o;
  logic        dbg_data_line_in_o, dbg_clock_line_in_o, port0_irq_o, port1_irq_o, dplus_irq_o;
  logic [2:0]  sfr_bit_idx_i = '0;
  logic [5:0]  observation_output_select_i = '0, radio_observe_signal_i = '0;
  logic [7:0]  sfr_addr_i = '0, sfr_wdata_i = '0, sfr_rdata_o, external_data_space_rdata_o, pad_in_i, drv = '0;
  logic [7:0]  pad_out_o, pad_oe_o, pull_up_o, pull_down_o, drv_en = 8'hff;
  logic [15:0] external_data_space_addr_i = '0, periph_out_i = '0, periph_oe_i = '0, periph_in_o;
  int          fail_count = 0, checked = 0;
  // address, value written, value read back
  logic [23:0] wt [14] = '{24'h80a505, 24'h905a0a, 24'h89ff00, 24'h8bff00, 24'h8fffcf,
    24'hf7ffef, 24'hf35a5a, 24'hf4a5a5, 24'hf53c3c, 24'hf6c3c3, 24'h8cffff, 24'hfdffff,
    24'habff0f, 24'h81ff00};
  small_gpio_port_block i_small_gpio_port_block (.*);
  pin_world i_pin_world (.clk_i, .out_i(pad_out_o), .oe_i(pad_oe_o), .pu_i(pull_up_o),
    .pd_i(pull_down_o), .drv_i(drv), .drv_en_i(drv_en), .lvl_o(pad_in_i));
  initial forever #10 clk_i = ~clk_i;
  task automatic chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // kind 0 byte write, 1 bit write, 2 register read, 3 alias read
  task automatic acc(input int kind, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {external_data_space_addr_i, sfr_wdata_i, sfr_bit_idx_i, sfr_bit_val_i} = {a, d, d[2:0], d[7]};
    sfr_addr_i = a[7:0];
    {sfr_wr_i, sfr_bit_wr_i, sfr_rd_i, external_data_space_rd_i} = 4'h8 >> kind;
    @(negedge clk_i);
    {sfr_wr_i, sfr_bit_wr_i, sfr_rd_i, external_data_space_rd_i} = 4'h0;
    if (kind > 1)
      chk(kind == 2 ? sfr_rdata_o : external_data_space_rdata_o, d);
  endtask
  // eight idle cycles after release let the edge logic finish priming
  task automatic do_reset();
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100us;
    fail_count++;
    summarize();
  end
  initial begin
    do_reset();
    foreach (wt[k])
      acc(2, wt[k][23:16], (wt[k][23:16] & 8'hef) == 8'h80 ? 8'h0f : '0);
    foreach (wt[k]) begin
      acc(0, wt[k][23:16], wt[k][15:8]);
      acc(2, wt[k][23:16], wt[k][7:0]);
    end
    chk(low_supply_drive_boost_o, 1'b1);
    acc(1, 8'h80, 8'h02);
    acc(3, 16'h7080, 8'h01);
    acc(3, 16'h7090, 8'h0a);
    acc(3, 16'h7081, 8'h00);
    $display("registers done");
    do_reset();
    drv_en = 8'h00;
    acc(0, 8'hf7, 8'hc1);
    repeat (2) @(negedge clk_i);
    chk({pull_up_o, pull_down_o}, 16'h0ec1);
    acc(0, 8'h8f, 8'h0f);
    repeat (2) @(negedge clk_i);
    chk({pull_up_o, pull_down_o}, 16'h00c0);
    drv_en = 8'hff;
    acc(0, 8'hfd, 8'h0f);
    acc(0, 8'h80, 8'h0a);
    repeat (2) @(negedge clk_i);
    chk({pad_oe_o, pad_out_o[3:0]}, 12'h0fa);
    {debug_mode_i, dbg_data_line_oe_i, dbg_data_line_out_i} = 3'b111;
    drv = 8'h40;
    repeat (6) @(negedge clk_i);
    chk({pad_oe_o[7:6], pad_out_o[7], pull_up_o[7:6], pull_down_o[7:6],
      dbg_clock_line_in_o, dbg_data_line_in_o}, 9'h143);
    debug_mode_i = 1'b0;
    {observation_output_select_i, radio_observe_signal_i} = {6'h04, 6'h04};
    repeat (2) @(negedge clk_i);
    chk({pad_oe_o[0], pad_out_o[0]}, 2'b11);
    observation_output_select_i = 6'h00;
    acc(0, 8'hf3, 8'h33);
    {periph_out_i[3], periph_oe_i[3]} = 2'b11;
    repeat (2) @(negedge clk_i);
    chk({pad_oe_o[1:0], pad_out_o[1:0]}, 4'hf);
    periph_oe_i[3] = 1'b0;
    acc(0, 8'hfd, 8'h00);
    drv = 8'h02;
    repeat (6) @(negedge clk_i);
    chk(periph_in_o[3], 1'b1);
    $display("pins done");
    acc(0, 8'h8c, 8'h01);
    acc(0, 8'h89, 8'h00);
    acc(0, 8'h8a, 8'h00);
    acc(0, 8'hab, 8'h0f);
    drv = 8'h11;
    repeat (6) @(negedge clk_i);
    acc(2, 8'h89, 8'h00);
    acc(2, 8'h8a, 8'h01);
    chk(port1_irq_o, 1'b0);
    drv = 8'h02;
    repeat (6) @(negedge clk_i);
    acc(2, 8'h89, 8'h03);
    chk(port0_irq_o, 1'b1);
    acc(0, 8'h89, 8'hfe);
    acc(2, 8'h89, 8'h02);
    acc(0, 8'hab, 8'h00);
    repeat (2) @(negedge clk_i);
    chk(port0_irq_o, 1'b0);
    dplus_i = 1'b1;
    repeat (6) @(negedge clk_i);
    acc(2, 8'h8b, 8'h00);
    dplus_i = 1'b0;
    acc(0, 8'hac, 8'h20);
    repeat (6) @(negedge clk_i);
    acc(2, 8'h8b, 8'h20);
    chk(dplus_irq_o, 1'b1);
    $display("edge flags done");
    summarize();
  end
endmodule
`default_nettype wire

//--- rtl/edge_sync_if.sv
// Purpose: carries filtered pin levels and edge pulses
// Assumes: one clock, all fields on clk_i
// Notes:   src is the synchroniser, dst the port block
`timescale 1ns/1ps
`default_nettype none
interface edge_sync_if #(parameter int W = 9);
  logic [W-1:0] level;  // debounced pin level
  logic [W-1:0] rise;   // one-cycle pulse per rising edge
  logic [W-1:0] fall;   // one-cycle pulse per falling edge
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

//--- rtl/gpio_pkg.sv
// Purpose: shared constants and types of the small gpio port block
// Assumes: eight pins, p1[3:0] in bits 7..4 and p0[3:0] in bits 3..0
// Notes:   special-function and alias addresses live here only
package gpio_pkg;
  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int NUM_PINS   = 8;     // pins of both ports
  localparam int PORT_W     = 4;     // pins per port
  localparam int FN_CODE_W  = 4;     // function code per pin
  localparam int NUM_FN     = 16;    // function codes in total
  localparam int NUM_OBS    = 6;     // observation outputs
  localparam int NUM_FSEL   = 4;     // function select registers
  localparam int SYNC_W     = 9;     // eight pins plus usb d+

  // ***************************************************************
  // special-function register addresses
  // ***************************************************************
  localparam logic [7:0] ADDR_PORT0_DATA  = 8'h80;
  localparam logic [7:0] ADDR_PORT0_FLAGS = 8'h89;
  localparam logic [7:0] ADDR_PORT1_FLAGS = 8'h8a;
  localparam logic [7:0] ADDR_DPLUS_FLAG  = 8'h8b;
  localparam logic [7:0] ADDR_EDGE_POL    = 8'h8c;
  localparam logic [7:0] ADDR_PORT1_MASK  = 8'h8d;
  localparam logic [7:0] ADDR_INPUT_MODE  = 8'h8f;
  localparam logic [7:0] ADDR_PORT1_DATA  = 8'h90;
  localparam logic [7:0] ADDR_PORT0_MASK  = 8'hab;
  localparam logic [7:0] ADDR_DPLUS_MASK  = 8'hac;
  localparam logic [7:0] ADDR_P0_LO_FSEL  = 8'hf3;
  localparam logic [7:0] ADDR_P0_HI_FSEL  = 8'hf4;
  localparam logic [7:0] ADDR_P1_LO_FSEL  = 8'hf5;
  localparam logic [7:0] ADDR_P1_HI_FSEL  = 8'hf6;
  localparam logic [7:0] ADDR_PULL_DRIVE  = 8'hf7;
  localparam logic [7:0] ADDR_PIN_DIR     = 8'hfd;

  // read-only aliases in the external data space
  localparam logic [15:0] XADDR_PORT0_DATA = 16'h7080;
  localparam logic [15:0] XADDR_PORT1_DATA = 16'h7090;

  // ***************************************************************
  // reset values, fields and pin roles
  // ***************************************************************
  localparam logic [3:0] PORT_DATA_RST  = 4'hf;
  localparam logic [7:0] REG_RST        = 8'h00;
  localparam logic [3:0] NIB_RST        = 4'h0;
  localparam logic [3:0] FN_GPIO        = 4'h0;
  localparam logic [7:0] INMODE_WMASK   = 8'hcf;  // bits 5,4 read zero
  localparam logic [7:0] INMODE_FORCED  = 8'h30;  // high-drive pins 3-state
  localparam logic [7:0] PULL_WMASK     = 8'hef;  // bit 4 unused
  localparam int         DRIVE_BOOST_BIT = 5;
  localparam int         DPLUS_BIT       = 5;
  localparam int         DPLUS_SYNC_IDX  = 8;
  localparam int         PIN_DBG_CLOCK   = 6;     // port 1 bit 2
  localparam int         PIN_DBG_DATA    = 7;     // port 1 bit 3
  localparam int         BIT_IDX_W       = 3;
  // observation output k drives this pin
  localparam int unsigned OBS_PIN_OF [0:NUM_OBS-1] = '{4, 5, 0, 1, 2, 3};

  // ***************************************************************
  // synchroniser start-up
  // ***************************************************************
  localparam logic [1:0] SYNC_FILL_CYCLES = 2'd3;
  typedef enum logic {
    SYNC_PRIME = 1'b0,
    SYNC_RUN   = 1'b1
  } sync_state_t;
endpackage

//--- rtl/pin_edge_sync.sv
// Purpose: three-stage pin synchroniser with edge pulses
// Assumes: raw inputs are asynchronous to clk_i
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync
  import gpio_pkg::*;
#(
  parameter int W = SYNC_W
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] raw_i,
  edge_sync_if.src          ev
);
  logic [W-1:0] s1_q, s2_q, s3_q;  // synchroniser chain
  logic [W-1:0] lvl_q;             // accepted level
  logic [W-1:0] rise_q, fall_q;    // edge pulses
  logic [W-1:0] agree;             // stages two and three match
  logic [1:0]   fill_q;            // start-up fill count
  sync_state_t  st_q;

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign agree = ~(s2_q ^ s3_q);

  // prime without edges so pulled-high pins give no false flag
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q   <= SYNC_PRIME;
      fill_q <= '0;
    end else if (st_q == SYNC_PRIME) begin
      fill_q <= fill_q + 2'd1;
      if (fill_q == SYNC_FILL_CYCLES) begin
        st_q <= SYNC_RUN;
      end
    end
  end

  // one pulse per accepted change of level
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lvl_q  <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      unique case (st_q)
        SYNC_PRIME: begin
          // newest settled stage: a pin that settles just after release
          // is already the known level once edges start to count
          lvl_q  <= s2_q;
          rise_q <= '0;
          fall_q <= '0;
        end
        SYNC_RUN: begin
          lvl_q  <= (agree & s3_q) | (~agree & lvl_q);
          rise_q <= agree & s3_q & ~lvl_q;
          fall_q <= agree & ~s3_q & lvl_q;
        end
      endcase
    end
  end

  assign ev.level = lvl_q;
  assign ev.rise  = rise_q;
  assign ev.fall  = fall_q;
endmodule
`default_nettype wire

//--- rtl/small_gpio_port_block.sv
// Purpose: eight-pin port with function select, pulls and edge flags
// Assumes: special-function bus on clk_i, one access per cycle
// Notes:   all outputs are flopped, so pins follow registers by one cycle
`timescale 1ns/1ps
`default_nettype none

module small_gpio_port_block
  import gpio_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire logic [7:0]           sfr_addr_i,
  input  wire logic                 sfr_wr_i,
  input  wire logic                 sfr_rd_i,
  input  wire logic [7:0]           sfr_wdata_i,
  input  wire logic                 sfr_bit_wr_i,
  input  wire logic [BIT_IDX_W-1:0] sfr_bit_idx_i,
  input  wire logic                 sfr_bit_val_i,
  output logic [7:0]                sfr_rdata_o,
  input  wire logic [15:0]          external_data_space_addr_i,
  input  wire logic                 external_data_space_rd_i,
  output logic [7:0]                external_data_space_rdata_o,
  input  wire logic [NUM_PINS-1:0]  pad_in_i,
  output logic [NUM_PINS-1:0]       pad_out_o,
  output logic [NUM_PINS-1:0]       pad_oe_o,
  output logic [NUM_PINS-1:0]       pull_up_o,
  output logic [NUM_PINS-1:0]       pull_down_o,
  output logic                      low_supply_drive_boost_o,
  input  wire logic                 dplus_i,
  input  wire logic                 debug_mode_i,
  input  wire logic                 dbg_data_line_out_i,
  input  wire logic                 dbg_data_line_oe_i,
  output logic                      dbg_data_line_in_o,
  output logic                      dbg_clock_line_in_o,
  input  wire logic [NUM_OBS-1:0]   observation_output_select_i,
  input  wire logic [NUM_OBS-1:0]   radio_observe_signal_i,
  input  wire logic [NUM_FN-1:0]    periph_out_i,
  input  wire logic [NUM_FN-1:0]    periph_oe_i,
  output logic [NUM_FN-1:0]         periph_in_o,
  output logic                      port0_irq_o,
  output logic                      port1_irq_o,
  output logic                      dplus_irq_o
);
  // ***************************************************************
  // state
  // ***************************************************************
  logic [PORT_W-1:0] port0_pin_data_q;        // port 0 latch
  logic [PORT_W-1:0] port1_pin_data_q;        // port 1 latch
  logic [7:0]        fsel_q [0:NUM_FSEL-1];   // p0lo, p0hi, p1lo, p1hi
  logic [7:0]        pin_direction_q;         // one is output
  logic [7:0]        input_mode_select_q;     // one is 3-state
  logic [7:0]        pull_and_drive_select_q; // pull dir, boost
  logic [7:0]        edge_polarity_select_q;  // one is falling
  logic [PORT_W-1:0] port0_edge_flags_q;
  logic [PORT_W-1:0] port1_edge_flags_q;
  logic              dplus_negedge_flag_q;
  logic [PORT_W-1:0] port0_irq_mask_q;
  logic [PORT_W-1:0] port1_irq_mask_q;
  logic              dplus_irq_mask_q;

  // next values of the flopped outputs
  logic [NUM_PINS-1:0] out_d, oe_d, pup_d, pdn_d;
  logic [NUM_FN-1:0]   pin_in_d;
  logic [7:0]          rd_d, xrd_d;
  logic [NUM_PINS-1:0] set_d;                 // edge hits per pin
  logic [NUM_PINS-1:0] mode_eff;              // effective 3-state

  edge_sync_if #(.W(SYNC_W)) sync_bus ();

  // ***************************************************************
  // helpers
  // ***************************************************************
  // strobe for a whole-byte write to one address
  function automatic logic wr_hit(input logic [7:0] a);
    return sfr_wr_i && (sfr_addr_i == a);
  endfunction

  // function code of pin i, two pins per select register
  function automatic logic [FN_CODE_W-1:0] pin_code(input int i);
    logic [7:0] r;
    r = fsel_q[i / 2];
    return (i % 2 == 1) ? r[7:4] : r[3:0];
  endfunction

  // ***************************************************************
  // pin synchroniser
  // ***************************************************************
  pin_edge_sync #(.W(SYNC_W)) u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .raw_i  ({dplus_i, pad_in_i}),
    .ev     (sync_bus.src)
  );

  // ***************************************************************
  // configuration registers
  // ***************************************************************
  // port data, byte or single-bit write; upper nibble never stored
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port0_pin_data_q <= PORT_DATA_RST;
      port1_pin_data_q <= PORT_DATA_RST;
    end else begin
      if (wr_hit(ADDR_PORT0_DATA)) begin
        port0_pin_data_q <= sfr_wdata_i[PORT_W-1:0];
      end else if (sfr_bit_wr_i && sfr_addr_i == ADDR_PORT0_DATA
                   && !sfr_bit_idx_i[BIT_IDX_W-1]) begin
        port0_pin_data_q[sfr_bit_idx_i[1:0]] <= sfr_bit_val_i;
      end
      if (wr_hit(ADDR_PORT1_DATA)) begin
        port1_pin_data_q <= sfr_wdata_i[PORT_W-1:0];
      end else if (sfr_bit_wr_i && sfr_addr_i == ADDR_PORT1_DATA
                   && !sfr_bit_idx_i[BIT_IDX_W-1]) begin
        port1_pin_data_q[sfr_bit_idx_i[1:0]] <= sfr_bit_val_i;
      end
    end
  end

  // function select registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int r = 0; r < NUM_FSEL; r++) begin
        fsel_q[r] <= REG_RST;
      end
    end else begin
      if (wr_hit(ADDR_P0_LO_FSEL)) fsel_q[0] <= sfr_wdata_i;
      if (wr_hit(ADDR_P0_HI_FSEL)) fsel_q[1] <= sfr_wdata_i;
      if (wr_hit(ADDR_P1_LO_FSEL)) fsel_q[2] <= sfr_wdata_i;
      if (wr_hit(ADDR_P1_HI_FSEL)) fsel_q[3] <= sfr_wdata_i;
    end
  end

  // direction, input mode, pulls, edge polarity
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_direction_q         <= REG_RST;
      input_mode_select_q     <= REG_RST;
      pull_and_drive_select_q <= REG_RST;
      edge_polarity_select_q  <= REG_RST;
    end else begin
      if (wr_hit(ADDR_PIN_DIR)) begin
        pin_direction_q <= sfr_wdata_i;
      end
      if (wr_hit(ADDR_INPUT_MODE)) begin
        input_mode_select_q <= sfr_wdata_i & INMODE_WMASK;
      end
      if (wr_hit(ADDR_PULL_DRIVE)) begin
        pull_and_drive_select_q <= sfr_wdata_i & PULL_WMASK;
      end
      if (wr_hit(ADDR_EDGE_POL)) begin
        edge_polarity_select_q <= sfr_wdata_i;
      end
    end
  end

  // per-pin interrupt masks
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port0_irq_mask_q <= NIB_RST;
      port1_irq_mask_q <= NIB_RST;
      dplus_irq_mask_q <= 1'b0;
    end else begin
      if (wr_hit(ADDR_PORT0_MASK)) port0_irq_mask_q <= sfr_wdata_i[PORT_W-1:0];
      if (wr_hit(ADDR_PORT1_MASK)) port1_irq_mask_q <= sfr_wdata_i[PORT_W-1:0];
      if (wr_hit(ADDR_DPLUS_MASK)) dplus_irq_mask_q <= sfr_wdata_i[DPLUS_BIT];
    end
  end

  // ***************************************************************
  // edge flags
  // ***************************************************************
  // polarity picks the edge; masks and pin function play no part
  assign set_d = (sync_bus.rise[NUM_PINS-1:0] & ~edge_polarity_select_q)
               | (sync_bus.fall[NUM_PINS-1:0] & edge_polarity_select_q);

  // written zeros clear, ones keep; a same-cycle edge still sets
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port0_edge_flags_q   <= NIB_RST;
      port1_edge_flags_q   <= NIB_RST;
      dplus_negedge_flag_q <= 1'b0;
    end else begin
      port0_edge_flags_q <= (wr_hit(ADDR_PORT0_FLAGS)
                             ? port0_edge_flags_q & sfr_wdata_i[PORT_W-1:0]
                             : port0_edge_flags_q)
                            | set_d[PORT_W-1:0];
      port1_edge_flags_q <= (wr_hit(ADDR_PORT1_FLAGS)
                             ? port1_edge_flags_q & sfr_wdata_i[PORT_W-1:0]
                             : port1_edge_flags_q)
                            | set_d[NUM_PINS-1:PORT_W];
      dplus_negedge_flag_q <= (wr_hit(ADDR_DPLUS_FLAG)
                               ? dplus_negedge_flag_q & sfr_wdata_i[DPLUS_BIT]
                               : dplus_negedge_flag_q)
                              | sync_bus.fall[DPLUS_SYNC_IDX];
    end
  end

  // requests follow flags and masks one cycle later
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port0_irq_o <= 1'b0;
      port1_irq_o <= 1'b0;
      dplus_irq_o <= 1'b0;
    end else begin
      port0_irq_o <= |(port0_edge_flags_q & port0_irq_mask_q);
      port1_irq_o <= |(port1_edge_flags_q & port1_irq_mask_q);
      dplus_irq_o <= dplus_negedge_flag_q & dplus_irq_mask_q;
    end
  end

  // ***************************************************************
  // pin multiplexing
  // ***************************************************************
  // high-drive pins behave as 3-state whatever the register holds
  assign mode_eff = input_mode_select_q | INMODE_FORCED;

  // priority: debug, then observation, then peripheral, then gpio
  always_comb begin
    out_d = {port1_pin_data_q, port0_pin_data_q};
    oe_d  = pin_direction_q;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_code(i) != FN_GPIO) begin
        // peripheral drives every pin it is mapped to
        out_d[i] = periph_out_i[pin_code(i)];
        oe_d[i]  = periph_oe_i[pin_code(i)];
      end
    end
    for (int k = 0; k < NUM_OBS; k++) begin
      if (observation_output_select_i[k]) begin
        out_d[OBS_PIN_OF[k]] = radio_observe_signal_i[k];
        oe_d[OBS_PIN_OF[k]]  = 1'b1;
      end
    end
    if (debug_mode_i) begin
      out_d[PIN_DBG_DATA]  = dbg_data_line_out_i;
      oe_d[PIN_DBG_DATA]   = dbg_data_line_oe_i;
      out_d[PIN_DBG_CLOCK] = 1'b0;
      oe_d[PIN_DBG_CLOCK]  = 1'b0;
    end
  end

  // pulls only on undriven pins in pull mode
  always_comb begin
    pup_d = ~mode_eff & ~oe_d & ~pull_and_drive_select_q;
    pdn_d = ~mode_eff & ~oe_d & pull_and_drive_select_q;
    if (debug_mode_i) begin
      pup_d[PIN_DBG_DATA]  = 1'b0;
      pup_d[PIN_DBG_CLOCK] = 1'b0;
      pdn_d[PIN_DBG_DATA]  = 1'b0;
      pdn_d[PIN_DBG_CLOCK] = 1'b0;
    end
  end

  // each peripheral input is the OR of all pins mapped to it
  always_comb begin
    pin_in_d = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_code(i) != FN_GPIO) begin
        pin_in_d[pin_code(i)] = pin_in_d[pin_code(i)] | sync_bus.level[i];
      end
    end
  end

  // pad-facing outputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pad_out_o                <= '0;
      pad_oe_o                 <= '0;
      pull_up_o                <= '0;
      pull_down_o              <= '0;
      low_supply_drive_boost_o <= 1'b0;
      periph_in_o              <= '0;
      dbg_data_line_in_o       <= 1'b0;
      dbg_clock_line_in_o      <= 1'b0;
    end else begin
      pad_out_o                <= out_d;
      pad_oe_o                 <= oe_d;
      pull_up_o                <= pup_d;
      pull_down_o              <= pdn_d;
      low_supply_drive_boost_o <= pull_and_drive_select_q[DRIVE_BOOST_BIT];
      periph_in_o              <= pin_in_d;
      dbg_data_line_in_o       <= sync_bus.level[PIN_DBG_DATA];
      dbg_clock_line_in_o      <= sync_bus.level[PIN_DBG_CLOCK];
    end
  end

  // ***************************************************************
  // read paths
  // ***************************************************************
  // unmapped addresses and unused bits read zero
  always_comb begin
    rd_d = '0;
    unique case (sfr_addr_i)
      ADDR_PORT0_DATA:  rd_d[PORT_W-1:0] = port0_pin_data_q;
      ADDR_PORT1_DATA:  rd_d[PORT_W-1:0] = port1_pin_data_q;
      ADDR_PORT0_FLAGS: rd_d[PORT_W-1:0] = port0_edge_flags_q;
      ADDR_PORT1_FLAGS: rd_d[PORT_W-1:0] = port1_edge_flags_q;
      ADDR_DPLUS_FLAG:  rd_d[DPLUS_BIT]  = dplus_negedge_flag_q;
      ADDR_EDGE_POL:    rd_d = edge_polarity_select_q;
      ADDR_INPUT_MODE:  rd_d = input_mode_select_q;
      ADDR_PULL_DRIVE:  rd_d = pull_and_drive_select_q;
      ADDR_PIN_DIR:     rd_d = pin_direction_q;
      ADDR_P0_LO_FSEL:  rd_d = fsel_q[0];
      ADDR_P0_HI_FSEL:  rd_d = fsel_q[1];
      ADDR_P1_LO_FSEL:  rd_d = fsel_q[2];
      ADDR_P1_HI_FSEL:  rd_d = fsel_q[3];
      ADDR_PORT0_MASK:  rd_d[PORT_W-1:0] = port0_irq_mask_q;
      ADDR_PORT1_MASK:  rd_d[PORT_W-1:0] = port1_irq_mask_q;
      ADDR_DPLUS_MASK:  rd_d[DPLUS_BIT]  = dplus_irq_mask_q;
      default:          rd_d = '0;
    endcase
  end

  // alias space has no write path at all
  always_comb begin
    xrd_d = '0;
    if (external_data_space_addr_i == XADDR_PORT0_DATA) begin
      xrd_d[PORT_W-1:0] = port0_pin_data_q;
    end else if (external_data_space_addr_i == XADDR_PORT1_DATA) begin
      xrd_d[PORT_W-1:0] = port1_pin_data_q;
    end
  end

  // read data held until the next read
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sfr_rdata_o   <= '0;
      external_data_space_rdata_o <= '0;
    end else begin
      if (sfr_rd_i) sfr_rdata_o <= rd_d;
      if (external_data_space_rd_i) external_data_space_rdata_o <= xrd_d;
    end
  end
endmodule
`default_nettype wire
